// [hdl/din_cond_pkg.sv]
/*
 * Constants for the digital input conditioning block: object indices,
 * entry numbers, reset values, field positions and routing codes.
 * Assumes a single 40 MHz clock and a 32-bit object dictionary port.
 */
package din_cond_pkg;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int INPUT_COUNT = 16;
    localparam int STATE_WIDTH = 32;
    localparam int CODE_WIDTH = 8;

    localparam logic [15:0] SWITCH_OBJECT = 16'h3225;
    localparam logic [15:0] CONTROL_OBJECT = 16'h3240;

    localparam logic [7:0] ENTRY_COUNT = 8'h00;
    localparam logic [7:0] ENTRY_SWITCH_VALUE = 8'h01;
    localparam logic [7:0] ENTRY_SPECIAL_ENABLE = 8'h01;
    localparam logic [7:0] ENTRY_INVERT = 8'h02;
    localparam logic [7:0] ENTRY_FORCE_ENABLE = 8'h03;
    localparam logic [7:0] ENTRY_FORCE_VALUE = 8'h04;
    localparam logic [7:0] ENTRY_RAW_LEVEL = 8'h05;
    localparam logic [7:0] ENTRY_THRESHOLD = 8'h06;
    localparam logic [7:0] ENTRY_DIFFERENTIAL = 8'h07;
    localparam logic [7:0] ENTRY_ROUTING = 8'h08;

    localparam logic [7:0] SWITCH_ENTRY_COUNT_VALUE = 8'h01;
    localparam logic [7:0] CONTROL_ENTRY_COUNT_VALUE = 8'h08;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

    localparam int BIT_NEG_LIMIT = 0;
    localparam int BIT_POS_LIMIT = 1;
    localparam int BIT_HOME = 2;
    localparam int BIT_INTERLOCK = 3;
    localparam int BIT_ROUTING_ON = 0;

    // Inputs that can act as step clock and direction, and input capabilities.
    localparam logic [15:0] CLOCK_DIR_INPUTS = 16'h0003;
    localparam logic [15:0] THRESHOLD_CAPABLE = 16'hFFFF;
    localparam logic [15:0] DIFFERENTIAL_CAPABLE = 16'h0003;

    localparam logic [7:0] CODE_CONST_ZERO = 8'h00;
    localparam logic [7:0] CODE_CONST_ONE = 8'h80;
    localparam logic [7:0] CODE_INPUT_FIRST = 8'h01;
    localparam logic [7:0] CODE_INPUT_LAST = 8'h10;
    localparam int CODE_INVERT_BIT = 7;

    // Switch capture waits for the synchroniser to fill after reset release.
    localparam logic [1:0] SWITCH_SETTLE_CYCLES = 2'h3;

    typedef enum logic [1:0] {
        SWITCH_WAIT = 2'b01,
        SWITCH_HELD = 2'b10
    } switch_state_type;
endpackage : din_cond_pkg

// [hdl/route_if.sv]
/*
 * Carrier between the conditioning top and its routing selector.
 * Assumes both ends share the conditioning clock; the path is combinational.
 */
interface route_if;
    timeunit 1ns;
    timeprecision 100ps;
    logic [din_cond_pkg::STATE_WIDTH-1:0] stage;
    logic [din_cond_pkg::STATE_WIDTH*din_cond_pkg::CODE_WIDTH-1:0] select;
    logic [din_cond_pkg::STATE_WIDTH-1:0] routed;

    modport conditioner (output stage, output select, input routed);
    modport selector (input stage, input select, output routed);
endinterface : route_if

// [hdl/input_router.sv]
/*
 * Per-bit source selection for the conditioned input state.
 * Assumes stage carries the inverted and forced input values, bit n for input n+1.
 */
module input_router (
    route_if.selector bus
);
    timeunit 1ns;
    timeprecision 100ps;
    // Decodes one routing code against the staged inputs.
    function automatic logic pick_source(
        input logic [7:0] code,
        input logic [din_cond_pkg::STATE_WIDTH-1:0] stage
    );
        logic [7:0] base;
        logic value;
        base = {1'b0, code[6:0]};
        value = 1'b0;
        if (base >= din_cond_pkg::CODE_INPUT_FIRST && base <= din_cond_pkg::CODE_INPUT_LAST) begin
            value = stage[4'(base - din_cond_pkg::CODE_INPUT_FIRST)];
        end
        if (code == din_cond_pkg::CODE_CONST_ZERO) begin
            value = 1'b0;
        end
        if (code == din_cond_pkg::CODE_CONST_ONE) begin
            value = 1'b1;
        end else if (code[din_cond_pkg::CODE_INVERT_BIT]) begin
            value = ~value;
        end
        return value;
    endfunction : pick_source

    genvar n;
    generate
        for (n = 0; n < din_cond_pkg::STATE_WIDTH; n++) begin : g_bit
            // Bit n takes the code of selector entry n+1.
            assign bus.routed[n] = pick_source(bus.select[n*8 +: 8], bus.stage); // see R16
        end
    endgenerate
endmodule : input_router

// [hdl/digital_input_conditioning.sv]
/*
 * Digital input conditioning: synchronises the input pins, applies inversion,
 * forcing and routing to build the conditioned input state, drives the special
 * functions and receiver settings, captures the address switches once after
 * restart, and serves the object dictionary entries of both objects.
 * Assumes the pins and switches are asynchronous, the routing source table
 * comes from logic on the same clock, and requests arrive one at a time.
 */
// Summary of operation
// R1: The address switches are sampled once after restart and held until the next restart.
// R2: The switch value entry holds switch two in its upper byte and switch one in its lower byte.
// R3: A special-function enable bit of 1 turns an input's special function on, 0 ignores it.
// R4: Bits 16 to 31 of the special-function enable word have no effect on any input.
// R5: Enable bits 0 to 3 map to negative limit, positive limit, home and interlock.
// R6: An inversion bit of 0 passes a high level as 1, a bit of 1 turns a high level into 0.
// R7: Inversion bit n controls input n+1 and applies to normal and special-function inputs.
// R8: Inputs serving as step clock or direction are never inverted.
// R9: A force-enable bit of 1 replaces the pin level of that input by a software value.
// R10: A forced input takes the bit at the same position of the force value word.
// R11: The raw value entry shows the synchronised pin levels untouched by later stages.
// R12: A range-select bit picks 5 V at 0 and 24 V at 1 on capable inputs, bit 0 for input 1.
// R13: A differential-select bit picks differential reception at 1 on capable inputs only.
// R14: Writing 1 to routing enable builds the conditioned state from the routing sources.
// R15: The control object reports 08h entries and the switch object reports 01h.
// R16: With routing on, state bit n follows selector entry n+1 with constant and inverted codes.
// R17: Each state bit is inverted first, then forced, then routed.
module digital_input_conditioning (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic [15:0] INPUT_PIN,
    input wire logic [7:0] SWITCH_ONE,
    input wire logic [7:0] SWITCH_TWO,
    input wire logic CLOCK_DIR_MODE,
    input wire logic [255:0] ROUTE_SELECT,
    input wire logic [15:0] OD_INDEX,
    input wire logic [7:0] OD_ENTRY,
    input wire logic OD_WRITE,
    input wire logic OD_READ,
    input wire logic [31:0] OD_WDATA,
    output logic [31:0] OD_RDATA,
    output logic OD_ACK,
    output logic OD_ERROR,
    output logic [31:0] CONDITIONED_INPUT_STATE,
    output logic NEG_LIMIT,
    output logic POS_LIMIT,
    output logic HOME,
    output logic INTERLOCK,
    output logic [15:0] THRESHOLD_24V,
    output logic [15:0] DIFFERENTIAL_ON
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] pin_meta;
    logic [15:0] pin_level;
    logic [15:0] switch_meta;
    logic [15:0] switch_sync;
    logic [15:0] switch_value;
    logic [1:0] settle_count;
    din_cond_pkg::switch_state_type switch_state;
    logic [31:0] special_enable;
    logic [31:0] input_invert;
    logic [31:0] force_enable;
    logic [31:0] force_value;
    logic [31:0] threshold_select;
    logic [31:0] differential_select;
    logic [31:0] routing_enable;
    logic [31:0] invert_mask;
    logic [31:0] next_stage;
    logic [31:0] next_state;
    logic is_switch;
    logic is_control;
    logic entry_known;
    logic entry_writable;
    logic [31:0] read_value;

    route_if route ();

    input_router u_router (
        .bus(route.selector)
    );

    // Pins come from outside the clock domain.
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            pin_meta <= 16'h0000;
            pin_level <= 16'h0000;
            switch_meta <= 16'h0000;
            switch_sync <= 16'h0000;
        end else begin
            pin_meta <= INPUT_PIN;
            pin_level <= pin_meta;
            switch_meta <= {SWITCH_TWO, SWITCH_ONE};
            switch_sync <= switch_meta;
        end
    end

    // Capture the switches once, after the synchroniser has settled.
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            switch_state <= din_cond_pkg::SWITCH_WAIT;
            settle_count <= 2'h0;
            switch_value <= 16'h0000;
        end else begin
            unique case (switch_state)
                din_cond_pkg::SWITCH_WAIT: begin
                    settle_count <= settle_count + 2'h1;
                    if (settle_count == din_cond_pkg::SWITCH_SETTLE_CYCLES) begin
                        switch_value <= switch_sync; // see R1, see R2
                        switch_state <= din_cond_pkg::SWITCH_HELD;
                    end
                end
                din_cond_pkg::SWITCH_HELD: begin
                    switch_value <= switch_value; // see R1
                end
            endcase
        end
    end

    // Stage order: inversion, then forcing, then routing.
    always_comb begin
        invert_mask = input_invert;
        if (CLOCK_DIR_MODE) begin
            invert_mask = input_invert & ~{16'h0000, din_cond_pkg::CLOCK_DIR_INPUTS}; // see R8
        end
        next_stage = {16'h0000, pin_level} ^ invert_mask; // see R6, see R7, see R17
        next_stage = (next_stage & ~force_enable) | (force_value & force_enable); // see R9, see R10
        if (routing_enable[din_cond_pkg::BIT_ROUTING_ON]) begin
            next_state = route.routed; // see R14, see R17
        end else begin
            next_state = next_stage;
        end
    end

    assign route.stage = next_stage;
    assign route.select = ROUTE_SELECT;

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            CONDITIONED_INPUT_STATE <= 32'h0000_0000;
            NEG_LIMIT <= 1'b0;
            POS_LIMIT <= 1'b0;
            HOME <= 1'b0;
            INTERLOCK <= 1'b0;
        end else begin
            CONDITIONED_INPUT_STATE <= next_state;
            // Only the low enable bits are looked at; bits 16 to 31 are inert.
            NEG_LIMIT <= special_enable[din_cond_pkg::BIT_NEG_LIMIT]
                & next_state[din_cond_pkg::BIT_NEG_LIMIT]; // see R3, see R4, see R5
            POS_LIMIT <= special_enable[din_cond_pkg::BIT_POS_LIMIT]
                & next_state[din_cond_pkg::BIT_POS_LIMIT]; // see R3, see R5
            HOME <= special_enable[din_cond_pkg::BIT_HOME]
                & next_state[din_cond_pkg::BIT_HOME]; // see R3, see R5
            INTERLOCK <= special_enable[din_cond_pkg::BIT_INTERLOCK]
                & next_state[din_cond_pkg::BIT_INTERLOCK]; // see R3, see R5
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            THRESHOLD_24V <= 16'h0000;
            DIFFERENTIAL_ON <= 16'h0000;
        end else begin
            THRESHOLD_24V <= threshold_select[15:0] & din_cond_pkg::THRESHOLD_CAPABLE; // see R12
            DIFFERENTIAL_ON <= differential_select[15:0]
                & din_cond_pkg::DIFFERENTIAL_CAPABLE; // see R13
        end
    end

    // Object dictionary decode.
    always_comb begin
        is_switch = OD_INDEX == din_cond_pkg::SWITCH_OBJECT;
        is_control = OD_INDEX == din_cond_pkg::CONTROL_OBJECT;
        entry_known = 1'b0;
        entry_writable = 1'b0;
        read_value = 32'h0000_0000;
        if (is_switch) begin
            unique case (OD_ENTRY)
                din_cond_pkg::ENTRY_COUNT: begin
                    entry_known = 1'b1;
                    read_value = {24'h000000, din_cond_pkg::SWITCH_ENTRY_COUNT_VALUE}; // see R15
                end
                din_cond_pkg::ENTRY_SWITCH_VALUE: begin
                    entry_known = 1'b1;
                    read_value = {16'h0000, switch_value}; // see R2
                end
                default: begin
                end
            endcase
        end else if (is_control) begin
            entry_known = OD_ENTRY <= din_cond_pkg::ENTRY_ROUTING;
            entry_writable = entry_known && OD_ENTRY != din_cond_pkg::ENTRY_COUNT;
            unique case (OD_ENTRY)
                din_cond_pkg::ENTRY_COUNT: begin
                    read_value = {24'h000000, din_cond_pkg::CONTROL_ENTRY_COUNT_VALUE}; // see R15
                end
                din_cond_pkg::ENTRY_SPECIAL_ENABLE: read_value = special_enable;
                din_cond_pkg::ENTRY_INVERT: read_value = input_invert;
                din_cond_pkg::ENTRY_FORCE_ENABLE: read_value = force_enable;
                din_cond_pkg::ENTRY_FORCE_VALUE: read_value = force_value;
                din_cond_pkg::ENTRY_RAW_LEVEL: read_value = {16'h0000, pin_level}; // see R11
                din_cond_pkg::ENTRY_THRESHOLD: read_value = threshold_select;
                din_cond_pkg::ENTRY_DIFFERENTIAL: read_value = differential_select;
                din_cond_pkg::ENTRY_ROUTING: read_value = routing_enable;
                default: begin
                end
            endcase
        end
    end

    // Writes to the raw value entry are accepted but store nothing.
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            special_enable <= din_cond_pkg::CONTROL_RESET;
            input_invert <= din_cond_pkg::CONTROL_RESET;
            force_enable <= din_cond_pkg::CONTROL_RESET;
            force_value <= din_cond_pkg::CONTROL_RESET;
            threshold_select <= din_cond_pkg::CONTROL_RESET;
            differential_select <= din_cond_pkg::CONTROL_RESET;
            routing_enable <= din_cond_pkg::CONTROL_RESET;
        end else if (OD_WRITE && !OD_READ && is_control && entry_writable) begin
            // A read in the same cycle wins, so nothing is stored then.
            unique case (OD_ENTRY)
                din_cond_pkg::ENTRY_SPECIAL_ENABLE: special_enable <= OD_WDATA; // see R4
                din_cond_pkg::ENTRY_INVERT: input_invert <= OD_WDATA;
                din_cond_pkg::ENTRY_FORCE_ENABLE: force_enable <= OD_WDATA;
                din_cond_pkg::ENTRY_FORCE_VALUE: force_value <= OD_WDATA;
                din_cond_pkg::ENTRY_THRESHOLD: threshold_select <= OD_WDATA;
                din_cond_pkg::ENTRY_DIFFERENTIAL: differential_select <= OD_WDATA;
                din_cond_pkg::ENTRY_ROUTING: routing_enable <= OD_WDATA; // see R14
                default: begin
                end
            endcase
        end
    end

    // One answer per request, one cycle after it is taken.
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            OD_RDATA <= 32'h0000_0000;
            OD_ACK <= 1'b0;
            OD_ERROR <= 1'b0;
        end else begin
            OD_ACK <= OD_READ || OD_WRITE;
            OD_ERROR <= 1'b0;
            if (OD_READ) begin
                OD_RDATA <= read_value;
                OD_ERROR <= !entry_known;
            end else if (OD_WRITE) begin
                OD_ERROR <= !entry_writable;
            end
        end
    end
endmodule : digital_input_conditioning

// [tb/din_cond_monitor.sv]
/* Checker for the input conditioning block: dictionary answers and masks.
   Bound from the bench top; sees only the block's top ports. */
module din_cond_monitor (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic [15:0] INPUT_PIN,
    input wire logic [15:0] OD_INDEX,
    input wire logic [7:0] OD_ENTRY,
    input wire logic OD_WRITE,
    input wire logic OD_READ,
    input wire logic [31:0] OD_RDATA,
    input wire logic OD_ACK,
    input wire logic OD_ERROR,
    input wire logic [15:0] DIFFERENTIAL_ON
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);

    AST_ACK_AFTER_REQ: assert property ((OD_READ || OD_WRITE) |=> OD_ACK)
        else $error("request without answer");
    AST_NO_STRAY_ACK: assert property (!(OD_READ || OD_WRITE) |=> !OD_ACK)
        else $error("answer without request");
    AST_CONTROL_COUNT: assert property (
        OD_READ && OD_INDEX == 16'h3240 && OD_ENTRY == 8'h00
        |=> OD_RDATA == 32'h0000_0008 && !OD_ERROR)
        else $error("control entry count wrong");
    AST_SWITCH_COUNT: assert property (
        OD_READ && OD_INDEX == 16'h3225 && OD_ENTRY == 8'h00
        |=> OD_RDATA == 32'h0000_0001 && !OD_ERROR)
        else $error("switch entry count wrong");
    AST_SWITCH_READ_ONLY: assert property (
        OD_WRITE && !OD_READ && OD_INDEX == 16'h3225 |=> OD_ACK && OD_ERROR)
        else $error("switch object write accepted");
    AST_RAW_LEVEL: assert property (
        ($stable(INPUT_PIN) [*3]) ##0 (OD_READ && OD_INDEX == 16'h3240 && OD_ENTRY == 8'h05)
        |=> OD_RDATA == {16'h0000, $past(INPUT_PIN)})
        else $error("raw value differs from pins");
    AST_UNKNOWN_INDEX: assert property (
        (OD_READ || OD_WRITE) && OD_INDEX != 16'h3225 && OD_INDEX != 16'h3240
        |=> OD_ACK && OD_ERROR)
        else $error("unknown object not refused");
    AST_DIFF_CAPABLE: assert property (DIFFERENTIAL_ON[15:2] == 14'h0000)
        else $error("differential on incapable input");
endmodule : din_cond_monitor

// [tb/field_inputs.sv]
/* Field switches and sensors: drives pin and rotary switch levels.
   Assumes the bench sets the wanted levels; changes land at falling edges. */
module field_inputs (
    input wire logic clock,
    input wire logic [15:0] wanted_pins,
    input wire logic [15:0] wanted_switch,
    output logic [15:0] pin_level,
    output logic [7:0] switch_one,
    output logic [7:0] switch_two
);
    timeunit 1ns;
    timeprecision 100ps;
    always @(negedge clock) begin
        pin_level <= wanted_pins;
        {switch_two, switch_one} <= wanted_switch;
    end
endmodule : field_inputs

// [tb/tb_top.sv]
/* Self-checking bench for the input conditioning block.
   Assumes a 40 MHz clock; inputs change at falling edges. */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, reset_n, cd_mode, od_write, od_read, od_ack, od_error;
    logic neg_lim, pos_lim, home, ilock;
    logic [15:0] pins, sw, od_index, pin_level, th24, diff_on;
    logic [7:0] od_entry, sw_one, sw_two;
    logic [255:0] route_sel;
    logic [31:0] od_wdata, od_rdata, state;
    int mismatches, samples_checked;

    field_inputs fld_u (.clock(clock), .wanted_pins(pins), .wanted_switch(sw),
        .pin_level(pin_level), .switch_one(sw_one), .switch_two(sw_two));
    digital_input_conditioning dut_u (.CLOCK(clock), .RESET_N(reset_n),
        .INPUT_PIN(pin_level), .SWITCH_ONE(sw_one), .SWITCH_TWO(sw_two),
        .CLOCK_DIR_MODE(cd_mode), .ROUTE_SELECT(route_sel), .OD_INDEX(od_index),
        .OD_ENTRY(od_entry), .OD_WRITE(od_write), .OD_READ(od_read),
        .OD_WDATA(od_wdata), .OD_RDATA(od_rdata), .OD_ACK(od_ack), .OD_ERROR(od_error),
        .CONDITIONED_INPUT_STATE(state), .NEG_LIMIT(neg_lim), .POS_LIMIT(pos_lim),
        .HOME(home), .INTERLOCK(ilock), .THRESHOLD_24V(th24), .DIFFERENTIAL_ON(diff_on));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Write when w is high, else read and expect d; x is the expected refusal.
    task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] e,
        input logic [31:0] d, input logic x);
        int n;
        {od_write, od_read} = {w, !w};
        {od_index, od_entry, od_wdata} = {i, e, d};
        @(negedge clock);
        {od_write, od_read} = 2'b00;
        n = 0;
        while (od_ack !== 1'b1 && n < 4) begin
            @(negedge clock);
            n++;
        end
        if (n == 4) begin
            mismatches++;
            end_sim();
        end
        check("error", {31'h0, x}, {31'h0, od_error});
        if (!w && !x) check("rdata", d, od_rdata);
    endtask : acc

    task automatic settle();
        repeat (4) @(negedge clock);
    endtask : settle

    task automatic t_reset();
        acc(1'b0, 16'h3240, 8'h00, 32'h0000_0008, 1'b0);
        acc(1'b0, 16'h3225, 8'h00, 32'h0000_0001, 1'b0);
        for (int e = 1; e < 9; e++) begin
            if (e != 5) acc(1'b0, 16'h3240, e[7:0], 32'h0, 1'b0);
        end
        acc(1'b0, 16'h3241, 8'h01, 32'h0, 1'b1);
        acc(1'b0, 16'h3240, 8'h09, 32'h0, 1'b1);
        acc(1'b1, 16'h3240, 8'h00, 32'h3, 1'b1);
    endtask : t_reset

    task automatic t_switch();
        acc(1'b0, 16'h3225, 8'h01, 32'h0000_C35A, 1'b0);
        sw = 16'h1234;
        settle();
        acc(1'b1, 16'h3225, 8'h01, 32'h0000_FFFF, 1'b1);
        acc(1'b0, 16'h3225, 8'h01, 32'h0000_C35A, 1'b0);
        reset_n = 1'b0;
        @(negedge clock);
        reset_n = 1'b1;
        repeat (6) @(negedge clock);
        acc(1'b0, 16'h3225, 8'h01, 32'h0000_1234, 1'b0);
    endtask : t_switch

    task automatic t_regs();
        for (int e = 1; e < 8; e++) begin
            if (e != 5) begin
                acc(1'b1, 16'h3240, e[7:0], 32'hA5C3_0000 | e, 1'b0);
                acc(1'b0, 16'h3240, e[7:0], 32'hA5C3_0000 | e, 1'b0);
                acc(1'b1, 16'h3240, e[7:0], 32'h0, 1'b0);
            end
        end
        acc(1'b1, 16'h3240, 8'h05, 32'hFFFF_FFFF, 1'b0);
        acc(1'b0, 16'h3240, 8'h05, 32'h0000_00F0, 1'b0);
    endtask : t_regs

    task automatic t_invert();
        acc(1'b1, 16'h3240, 8'h02, 32'h0001_0030, 1'b0);
        settle();
        check("state", 32'h0001_00C0, state);
        acc(1'b1, 16'h3240, 8'h02, 32'h0000_0003, 1'b0);
        {cd_mode, pins} = {1'b1, 16'h0003};
        settle();
        check("state", 32'h0000_0003, state);
        cd_mode = 1'b0;
        settle();
        check("state", 32'h0000_0000, state);
    endtask : t_invert

    task automatic t_force();
        pins = 16'h00F0;
        acc(1'b1, 16'h3240, 8'h02, 32'h0000_00FF, 1'b0);
        acc(1'b1, 16'h3240, 8'h03, 32'h8000_0011, 1'b0);
        acc(1'b1, 16'h3240, 8'h04, 32'h8000_0010, 1'b0);
        settle();
        check("state", 32'h8000_001E, state);
        acc(1'b0, 16'h3240, 8'h05, 32'h0000_00F0, 1'b0);
        acc(1'b1, 16'h3240, 8'h02, 32'h0, 1'b0);
        acc(1'b1, 16'h3240, 8'h03, 32'h0000_000F, 1'b0);
        acc(1'b1, 16'h3240, 8'h04, 32'h0000_000F, 1'b0);
        acc(1'b1, 16'h3240, 8'h01, 32'hFFFF_0000, 1'b0);
        settle();
        check("special", 32'h0, {28'h0000000, ilock, home, pos_lim, neg_lim});
        acc(1'b1, 16'h3240, 8'h01, 32'h0000_0005, 1'b0);
        settle();
        check("special", 32'h5, {28'h0000000, ilock, home, pos_lim, neg_lim});
        acc(1'b1, 16'h3240, 8'h01, 32'h0000_000A, 1'b0);
        settle();
        check("special", 32'hA, {28'h0000000, ilock, home, pos_lim, neg_lim});
        acc(1'b1, 16'h3240, 8'h04, 32'h0, 1'b0);
        settle();
        check("special", 32'h0, {28'h0000000, ilock, home, pos_lim, neg_lim});
        acc(1'b1, 16'h3240, 8'h03, 32'h0, 1'b0);
    endtask : t_force

    task automatic t_range();
        acc(1'b1, 16'h3240, 8'h06, 32'hFFFF_8001, 1'b0);
        acc(1'b1, 16'h3240, 8'h07, 32'hFFFF_FFFF, 1'b0);
        settle();
        check("range", 32'h8001, {16'h0, th24});
        check("differential", 32'h0003, {16'h0, diff_on});
    endtask : t_range

    task automatic t_route();
        pins = 16'h0001;
        route_sel[55:0] = 56'h41_10_90_81_01_80_00;
        acc(1'b1, 16'h3240, 8'h08, 32'h0000_0001, 1'b0);
        settle();
        check("state", 32'h0000_0016, state);
        pins = 16'h8000;
        settle();
        check("state", 32'h0000_002A, state);
        acc(1'b1, 16'h3240, 8'h08, 32'h0, 1'b0);
        settle();
        check("state", 32'h0000_8000, state);
    endtask : t_route

    initial begin
        {reset_n, cd_mode, od_write, od_read} = 4'h0;
        {od_index, od_entry, od_wdata, route_sel} = '0;
        {pins, sw} = {16'h00F0, 16'hC35A};
        mismatches = 0;
        samples_checked = 0;
        repeat (3) @(negedge clock);
        reset_n = 1'b1;
        repeat (6) @(negedge clock);
        t_reset();
        t_switch();
        t_regs();
        t_invert();
        t_force();
        t_range();
        t_route();
        end_sim();
    end
endmodule : tb_top

bind digital_input_conditioning din_cond_monitor mon_u (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .INPUT_PIN(INPUT_PIN), .OD_INDEX(OD_INDEX), .OD_ENTRY(OD_ENTRY), .OD_WRITE(OD_WRITE),
    .OD_READ(OD_READ), .OD_RDATA(OD_RDATA), .OD_ACK(OD_ACK), .OD_ERROR(OD_ERROR),
    .DIFFERENTIAL_ON(DIFFERENTIAL_ON));
